// [shared/mtx_pkg.sv]
// Shared constants of the transmit event and interrupt status block.
package mtx_pkg;

  // Register byte offsets on the APB.
  localparam logic [11:0] CMD_OFFSET = 12'h090;
  localparam logic [11:0] THR_OFFSET = 12'h094;
  localparam logic [11:0] IEN_OFFSET = 12'h0AC;
  localparam logic [11:0] IST_OFFSET = 12'h0B0;

  // Command register fields.
  localparam int CMD_NODEF_BIT = 0;
  localparam int CMD_FDUP_BIT = 1;
  localparam int CMD_SPD100_BIT = 2;
  localparam logic [2:0] CMD_RESET = 3'h0;

  // Transmit threshold field, in bytes held by the transmit FIFO.
  localparam int THR_WIDTH = 8;
  localparam logic [7:0] THR_RESET = 8'h40;

  // Status and enable share one layout: summary or master enable, then six flags.
  localparam int SUM_BIT = 16;
  localparam int FLAG_LSB = 17;
  localparam int FLAG_N = 6;
  localparam int F_UNDERFLOW = 0;
  localparam int F_COMPLETE = 1;
  localparam int F_EXDEFER = 2;
  localparam int F_NOCARRIER = 3;
  localparam int F_ABORT = 4;
  localparam int F_LATECOL = 5;
  localparam logic [5:0] FLAG_RESET = 6'h00;
  localparam logic [6:0] IEN_RESET = 7'h00;

  // Frame timing on the link, in link clock ticks (nibbles) and bytes.
  localparam logic [4:0] PREAMBLE_NIBS = 5'h10;
  localparam logic [4:0] JAM_NIBS = 5'h08;
  localparam logic [4:0] GAP_NIBS = 5'h18;
  localparam logic [4:0] NC_SETTLE_NIBS = 5'h04;
  localparam logic [6:0] LATE_BYTES = 7'h40;
  localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
  localparam logic [3:0] PREAMBLE_NIB = 4'h5;
  localparam logic [3:0] SFD_NIB = 4'hD;
  localparam logic [3:0] JAM_NIB = 4'h5;

  // Excessive deferral limits, as times and as system clock cycles.
  localparam int CLK_PERIOD_NS = 100;
  localparam int DEFER_100M_NS = 327680;
  localparam int DEFER_10M_NS = 3276800;
  localparam int DEFER_100M_CYC = (DEFER_100M_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEFER_10M_CYC_DEF = (DEFER_10M_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Transmit sequencer states.
  typedef enum logic [2:0] {
    MTX_IDLE,
    MTX_DEFER,
    MTX_PREAMBLE,
    MTX_DATA,
    MTX_END,
    MTX_JAM,
    MTX_GAP
  } mtx_state_type;

endpackage

// [verilog/mtx_sync.sv]
`timescale 1ns/1ps
// Two-stage synchroniser for a group of independent level inputs.
module mtx_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,              // System clock.
  input wire logic rst_n,                // Synchronous reset, active low.
  input wire logic [WIDTH-1:0] async_in, // Levels from outside the clock domain.
  output logic [WIDTH-1:0] sync_out      // Levels safe to use in sys_clk.
);

  // A zero-width group has nothing to synchronise.
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync_out;

  // The first stage feeds only the second stage.
  always_comb begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  // Both stages clear under reset so nothing reads stale levels.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end

endmodule

// [verilog/mtx_tx_event_status.sv]
`timescale 1ns/1ps
// Summary of operation
// - Late collision flag sets on collision after 64 data bytes were sent.
// - Late collision checked only in half duplex.
// - Sixteenth consecutive collision abandons the packet and sets the abort flag.
// - Collision abort happens only in half duplex.
// - Half duplex: no-carrier flag when carrier absent at start or drops mid-frame.
// - Excess-defer flag after deferring beyond 0.32768 ms (100M) or 3.2768 ms (10M).
// - Deferral check runs only with no-defer clear and in half duplex.
// - Transmit-complete flag sets on each successful packet.
// - Underflow flag sets when the FIFO runs empty mid-packet.
// - After underflow the packet is resent automatically.
// - Each flag with its enable bit drives the transmit summary.
// - Writing one to a flag clears it and its interrupt share.
// - Summary is OR of status bits 17-22 ANDed with matching enables.
// - Interrupt to the CPU needs both summary and master enable.
module mtx_tx_event_status
  import mtx_pkg::*;
#(
  parameter int DEFER_10M_CYC = DEFER_10M_CYC_DEF
) (
  input wire logic sys_clk,             // System clock, 10 MHz.
  input wire logic rst_n,               // Synchronous reset, active low.
  input wire logic [11:0] paddr,        // APB byte address.
  input wire logic psel,                // APB select.
  input wire logic penable,             // APB access phase.
  input wire logic pwrite,              // APB write when high.
  input wire logic [31:0] pwdata,       // APB write data.
  output logic [31:0] prdata,           // APB read data.
  output logic pready,                  // APB ready.
  output logic pslverr,                 // APB error on unmapped address.
  input wire logic mii_tx_clk,          // Transmit clock from the PHY.
  input wire logic mii_crs,             // Carrier sense from the PHY.
  input wire logic mii_col,             // Collision from the PHY.
  output logic [3:0] mii_txd,           // Transmit nibble to the PHY.
  output logic mii_tx_en,               // Transmit enable to the PHY.
  input wire logic tx_req,              // A frame waits in the transmit FIFO.
  input wire logic [7:0] tx_fifo_level, // Bytes now held by the transmit FIFO.
  input wire logic tx_byte_valid,       // FIFO offers a byte.
  input wire logic [7:0] tx_byte,       // Byte offered by the FIFO.
  input wire logic tx_byte_last,        // Offered byte ends the frame.
  output logic tx_byte_take,            // Pulse: offered byte consumed.
  output logic tx_rewind,               // Pulse: restart frame from its first byte.
  output logic tx_frame_done,           // Pulse: frame finished or dropped.
  output logic tx_irq                   // Transmit interrupt, active high level.
);

  // The long deferral limit must fit the 16-bit deferral counter.
  if (DEFER_10M_CYC < 1 || DEFER_10M_CYC > 65534) begin : g_bad_defer
    $error("DEFER_10M_CYC out of range");
  end

  localparam logic [15:0] LIM_10M = 16'(DEFER_10M_CYC);
  localparam logic [15:0] LIM_100M = 16'(DEFER_100M_CYC);

  logic [2:0] sync_bits;
  logic clk_s;
  logic crs_s;
  logic col_s;
  logic clk_prev;
  logic link_tick;

  // The PHY clock, carrier and collision are all asynchronous here.
  mtx_sync #(
    .WIDTH(3)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({mii_tx_clk, mii_crs, mii_col}),
    .sync_out(sync_bits)
  );

  assign clk_s = sync_bits[2];
  assign crs_s = sync_bits[1];
  assign col_s = sync_bits[0];
  // A nibble moves on each rising edge of the sampled link clock.
  assign link_tick = clk_s & ~clk_prev;

  // Register state.
  logic [2:0] cmd;
  logic [THR_WIDTH-1:0] tx_threshold;
  logic [FLAG_N-1:0] flags;
  logic [FLAG_N:0] ien;
  logic [2:0] next_cmd;
  logic [THR_WIDTH-1:0] next_tx_threshold;
  logic [FLAG_N-1:0] next_flags;
  logic [FLAG_N:0] next_ien;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [FLAG_N-1:0] set_evt;
  logic [FLAG_N-1:0] clr_req;
  logic summary;
  logic half;
  logic no_defer;
  logic [15:0] defer_lim;
  logic hit;
  logic wr_access;

  assign half = ~cmd[CMD_FDUP_BIT];
  assign no_defer = cmd[CMD_NODEF_BIT];
  assign defer_lim = cmd[CMD_SPD100_BIT] ? LIM_100M : LIM_10M;
  assign summary = |(flags & ien[FLAG_N:1]);
  assign tx_irq = summary & ien[0];
  // Zero wait states; read data is prepared during the setup cycle.
  assign pready = psel & penable;
  assign wr_access = psel & penable & pwrite;

  // Register group: address decode, read data, enables and sticky flags.
  always_comb begin
    next_cmd = cmd;
    next_tx_threshold = tx_threshold;
    next_ien = ien;
    next_prdata = prdata;
    next_pslverr = pslverr;
    clr_req = '0;
    hit = (paddr == CMD_OFFSET) || (paddr == THR_OFFSET) ||
          (paddr == IEN_OFFSET) || (paddr == IST_OFFSET);
    if (psel && !penable) begin
      next_pslverr = ~hit;
      next_prdata = 32'h0000_0000;
      case (paddr)
        CMD_OFFSET: next_prdata[2:0] = cmd;
        THR_OFFSET: next_prdata[THR_WIDTH-1:0] = tx_threshold;
        IEN_OFFSET: next_prdata[FLAG_LSB+FLAG_N-1:SUM_BIT] = ien;
        IST_OFFSET: next_prdata[FLAG_LSB+FLAG_N-1:SUM_BIT] = {flags, summary};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    if (wr_access) begin
      case (paddr)
        CMD_OFFSET: next_cmd = pwdata[2:0];
        THR_OFFSET: next_tx_threshold = pwdata[THR_WIDTH-1:0];
        IEN_OFFSET: next_ien = pwdata[FLAG_LSB+FLAG_N-1:SUM_BIT];
        IST_OFFSET: clr_req = pwdata[FLAG_LSB+FLAG_N-1:FLAG_LSB];
        default: next_cmd = cmd;
      endcase
    end
    // sticky, and a same-cycle event beats the clear.
    next_flags = (flags & ~clr_req) | set_evt;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmd <= CMD_RESET;
      tx_threshold <= THR_RESET;
      ien <= IEN_RESET;
      flags <= FLAG_RESET;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      cmd <= next_cmd;
      tx_threshold <= next_tx_threshold;
      ien <= next_ien;
      flags <= next_flags;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Transmit sequencer state.
  mtx_state_type state;
  mtx_state_type next_state;
  logic [3:0] next_txd;
  logic next_tx_en;
  logic [4:0] nib_cnt;
  logic [4:0] next_nib_cnt;
  logic nib_hi;
  logic next_nib_hi;
  logic [3:0] hold;
  logic [3:0] next_hold;
  logic last_l;
  logic next_last_l;
  logic [6:0] byte_cnt;
  logic [6:0] next_byte_cnt;
  logic [4:0] attempts;
  logic [4:0] next_attempts;
  logic [15:0] defer_cnt;
  logic [15:0] next_defer_cnt;
  logic defer_hit;
  logic next_defer_hit;
  logic nc_seen;
  logic next_nc_seen;
  logic next_rewind;
  logic next_done;

  // Transmit group: deferral, preamble, data nibbles, collisions and gap.
  always_comb begin
    next_state = state;
    next_txd = mii_txd;
    next_tx_en = mii_tx_en;
    next_nib_cnt = nib_cnt;
    next_nib_hi = nib_hi;
    next_hold = hold;
    next_last_l = last_l;
    next_byte_cnt = byte_cnt;
    next_attempts = attempts;
    next_defer_cnt = defer_cnt;
    next_defer_hit = defer_hit;
    next_nc_seen = nc_seen;
    next_rewind = 1'b0;
    next_done = 1'b0;
    set_evt = '0;
    tx_byte_take = 1'b0;
    // collisions only matter in half duplex
    if (half && col_s && (state == MTX_PREAMBLE || state == MTX_DATA)) begin
      next_nib_cnt = 5'h00;
      if (byte_cnt >= LATE_BYTES) begin
        set_evt[F_LATECOL] = 1'b1;
        next_done = 1'b1;
        next_attempts = 5'h00;
        next_tx_en = 1'b0;
        next_state = MTX_GAP;
      end else if (attempts == MAX_ATTEMPTS - 5'h01) begin
        set_evt[F_ABORT] = 1'b1;
        next_done = 1'b1;
        next_attempts = 5'h00;
        next_tx_en = 1'b0;
        next_state = MTX_GAP;
      end else begin
        next_attempts = attempts + 5'h01;
        next_rewind = 1'b1;
        next_txd = JAM_NIB;
        next_state = MTX_JAM;
      end
    end else begin
      case (state)
        MTX_IDLE: begin
          // threshold holds start until enough bytes wait
          if (tx_req && tx_fifo_level >= tx_threshold) begin
            next_state = MTX_DEFER;
            next_defer_cnt = 16'h0000;
            next_defer_hit = 1'b0;
          end
        end
        MTX_DEFER: begin
          if (half && crs_s) begin
            if (defer_cnt != 16'hFFFF) begin
              next_defer_cnt = defer_cnt + 16'h0001;
            end
            // only in half duplex with no-defer clear
            if (!no_defer && !defer_hit && defer_cnt == defer_lim) begin
              set_evt[F_EXDEFER] = 1'b1;
              next_defer_hit = 1'b1;
            end
          end else if (link_tick) begin
            next_state = MTX_PREAMBLE;
            next_tx_en = 1'b1;
            next_txd = PREAMBLE_NIB;
            next_nib_cnt = 5'h01;
            next_byte_cnt = 7'h00;
            next_nib_hi = 1'b0;
            next_nc_seen = 1'b0;
          end
        end
        MTX_PREAMBLE: begin
          if (link_tick) begin
            if (half && !crs_s && nib_cnt >= NC_SETTLE_NIBS) begin
              next_nc_seen = 1'b1;
            end
            next_nib_cnt = nib_cnt + 5'h01;
            next_txd = PREAMBLE_NIB;
            if (nib_cnt == PREAMBLE_NIBS - 5'h01) begin
              next_txd = SFD_NIB;
              next_state = MTX_DATA;
            end
          end
        end
        MTX_DATA: begin
          if (link_tick) begin
            if (half && !crs_s) begin
              next_nc_seen = 1'b1;
            end
            if (nib_hi) begin
              next_txd = hold;
              next_nib_hi = 1'b0;
              if (byte_cnt != LATE_BYTES) begin
                next_byte_cnt = byte_cnt + 7'h01;
              end
              if (last_l) begin
                next_state = MTX_END;
              end
            end else if (tx_byte_valid) begin
              tx_byte_take = 1'b1;
              next_txd = tx_byte[3:0];
              next_hold = tx_byte[7:4];
              next_last_l = tx_byte_last;
              next_nib_hi = 1'b1;
            end else begin
              set_evt[F_UNDERFLOW] = 1'b1;
              // resend the same packet on its own
              next_rewind = 1'b1;
              next_tx_en = 1'b0;
              next_nib_cnt = 5'h00;
              next_state = MTX_GAP;
            end
          end
        end
        MTX_END: begin
          if (link_tick) begin
            next_tx_en = 1'b0;
            set_evt[F_COMPLETE] = 1'b1;
            set_evt[F_NOCARRIER] = nc_seen;
            next_done = 1'b1;
            next_attempts = 5'h00;
            next_nib_cnt = 5'h00;
            next_state = MTX_GAP;
          end
        end
        MTX_JAM: begin
          if (link_tick) begin
            next_nib_cnt = nib_cnt + 5'h01;
            if (nib_cnt == JAM_NIBS - 5'h01) begin
              next_tx_en = 1'b0;
              next_nib_cnt = 5'h00;
              next_state = MTX_GAP;
            end
          end
        end
        MTX_GAP: begin
          // The gap also serves as a fixed backoff before any retry.
          if (link_tick) begin
            next_nib_cnt = nib_cnt + 5'h01;
            if (nib_cnt == GAP_NIBS - 5'h01) begin
              next_state = MTX_IDLE;
            end
          end
        end
        default: begin
          next_state = MTX_IDLE;
          next_tx_en = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= MTX_IDLE;
      clk_prev <= 1'b0;
      mii_txd <= 4'h0;
      mii_tx_en <= 1'b0;
      nib_cnt <= 5'h00;
      nib_hi <= 1'b0;
      hold <= 4'h0;
      last_l <= 1'b0;
      byte_cnt <= 7'h00;
      attempts <= 5'h00;
      defer_cnt <= 16'h0000;
      defer_hit <= 1'b0;
      nc_seen <= 1'b0;
      tx_rewind <= 1'b0;
      tx_frame_done <= 1'b0;
    end else begin
      state <= next_state;
      clk_prev <= clk_s;
      mii_txd <= next_txd;
      mii_tx_en <= next_tx_en;
      nib_cnt <= next_nib_cnt;
      nib_hi <= next_nib_hi;
      hold <= next_hold;
      last_l <= next_last_l;
      byte_cnt <= next_byte_cnt;
      attempts <= next_attempts;
      defer_cnt <= next_defer_cnt;
      defer_hit <= next_defer_hit;
      nc_seen <= next_nc_seen;
      tx_rewind <= next_rewind;
      tx_frame_done <= next_done;
    end
  end

endmodule

// [verif/mtx_tx_event_status_props.sv]
`timescale 1ns/1ps
// Pin-level checks of the transmit event block.
module mtx_tx_event_status_props
  import mtx_pkg::*;
#(
  parameter int DEFER_10M_CYC = DEFER_10M_CYC_DEF
) (
  input wire logic sys_clk,       // Clock.
  input wire logic rst_n,         // Reset.
  input wire logic [11:0] paddr,  // Address.
  input wire logic psel,          // Select.
  input wire logic penable,       // Access phase.
  input wire logic pwrite,        // Write.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready,        // Ready.
  input wire logic pslverr,       // Error.
  input wire logic [3:0] mii_txd, // Nibble.
  input wire logic mii_tx_en,     // Transmit enable.
  input wire logic tx_byte_valid, // Byte offered.
  input wire logic tx_byte_take,  // Byte taken.
  input wire logic tx_rewind,     // Restart.
  input wire logic tx_frame_done, // Done.
  input wire logic tx_irq         // Interrupt.
);
  logic acc;
  logic mapped;
  logic [6:0] ien;
  logic [6:0] next_ien;
  assign acc = psel & penable;
  assign mapped = paddr inside {CMD_OFFSET, THR_OFFSET, IEN_OFFSET, IST_OFFSET};
  // A copy of the enable register lets the interrupt be judged from bus traffic alone.
  always_comb begin
    next_ien = ien;
    if (!rst_n) begin
      next_ien = IEN_RESET;
    end else if (acc && pwrite && paddr == IEN_OFFSET) begin
      next_ien = pwdata[22:16];
    end
  end
  always_ff @(posedge sys_clk) begin
    ien <= next_ien;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_ready_no_wait:
    assert property (pready == acc) else $error("pready wrong");
  chk_unmapped_refused:
    assert property (acc && !mapped |-> pslverr && prdata == 32'h0) else $error("no refusal");
  chk_mapped_ok:
    assert property (acc && mapped |-> !pslverr) else $error("false error");
  chk_status_unused:
    assert property (acc && paddr == IST_OFFSET |-> prdata[31:23] == 9'h000
      && prdata[15:0] == 16'h0000) else $error("status spare bits set");
  chk_summary_or:
    assert property (acc && paddr == IST_OFFSET |-> prdata[16] == |(prdata[22:17] & ien[6:1]))
      else $error("summary wrong");
  chk_irq_master:
    assert property (tx_irq |-> ien[0]) else $error("irq without master");
  chk_irq_enable:
    assert property (tx_irq |-> ien[6:1] != 6'h00) else $error("irq without enable");
  chk_done_pulse:
    assert property (tx_frame_done |=> !tx_frame_done) else $error("done too long");
  chk_rewind_alone:
    assert property (!(tx_rewind && tx_frame_done)) else $error("rewind with done");
  chk_take_offered:
    assert property (tx_byte_take |-> tx_byte_valid && mii_tx_en) else $error("bad take");
  chk_preamble_first:
    assert property ($rose(mii_tx_en) |-> mii_txd == PREAMBLE_NIB) else $error("bad start");
  chk_gap_quiet:
    assert property ($fell(mii_tx_en) |=> !mii_tx_en [*8]) else $error("gap too short");
  cover property (tx_irq);
  cover property (tx_rewind);
  cover property (acc && pslverr);
  cover property (tx_frame_done);
endmodule

bind mtx_tx_event_status mtx_tx_event_status_props #(.DEFER_10M_CYC(DEFER_10M_CYC)) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mii_txd(mii_txd), .mii_tx_en(mii_tx_en), .tx_byte_valid(tx_byte_valid),
  .tx_byte_take(tx_byte_take), .tx_rewind(tx_rewind), .tx_frame_done(tx_frame_done),
  .tx_irq(tx_irq));

// [verif/mtx_phy_model.sv]
`timescale 1ns/1ps
// Behavioural PHY: link clock only while a frame is wanted, carrier and collision on command.
module mtx_phy_model (
  input wire logic run,          // Run the link clock.
  input wire logic busy,         // Another station holds the carrier.
  input wire logic echo,         // Carrier follows our own transmit enable.
  input wire logic [7:0] col_at, // Burst depth in nibbles where collision starts, zero never.
  input wire logic mii_tx_en,    // Transmit enable from the MAC.
  output logic mii_tx_clk,       // Link clock.
  output logic mii_crs,          // Carrier sense.
  output logic mii_col           // Collision.
);
  logic [7:0] nibs = 8'h00;
  // The clock is offset from the system clock so no edge relation is assumed, and stops low.
  initial begin
    mii_tx_clk = 1'b0;
    #137;
    forever #400 mii_tx_clk = run & ~mii_tx_clk;
  end
  // Counting the burst lets a collision land early or late in a frame.
  always @(posedge mii_tx_clk) begin
    nibs <= mii_tx_en ? nibs + 8'h01 : 8'h00;
  end
  assign mii_crs = busy | (echo & mii_tx_en);
  assign mii_col = (col_at != 8'h00) && mii_tx_en && (nibs >= col_at);
endmodule

// [verif/test_mtx_tx_event_status.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h want %h", $time, g, e); end end
module test_mtx_tx_event_status;
  import mtx_pkg::*;
  localparam logic [5:0] UF = 6'h01 << F_UNDERFLOW;
  localparam logic [5:0] CP = 6'h01 << F_COMPLETE;
  localparam logic [5:0] XD = 6'h01 << F_EXDEFER;
  localparam logic [5:0] NC = 6'h01 << F_NOCARRIER;
  localparam logic [5:0] AB = 6'h01 << F_ABORT;
  localparam logic [5:0] LC = 6'h01 << F_LATECOL;
  logic sys_clk = 1'b0;
  logic rst_n, psel, penable, pwrite, run, busy, echo, starve, tx_req, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic pready, pslverr, mii_tx_clk, mii_crs, mii_col, mii_tx_en;
  logic [3:0] mii_txd;
  logic [7:0] tx_byte, idx, col_at;
  logic tx_byte_take, tx_rewind, tx_frame_done, tx_irq;
  int errors = 0;
  int compares = 0;
  int len = 1;
  int nrew;
  always #50 sys_clk = ~sys_clk;
  mtx_tx_event_status #(.DEFER_10M_CYC(40)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mii_tx_clk(mii_tx_clk), .mii_crs(mii_crs), .mii_col(mii_col), .mii_txd(mii_txd),
    .mii_tx_en(mii_tx_en), .tx_req(tx_req), .tx_fifo_level(tx_req ? 8'hFF : 8'h00),
    .tx_byte_valid(tx_req & ~starve), .tx_byte(idx), .tx_byte_last(idx == 8'(len - 1)),
    .tx_byte_take(tx_byte_take), .tx_rewind(tx_rewind), .tx_frame_done(tx_frame_done),
    .tx_irq(tx_irq));
  mtx_phy_model u_phy (.run(run), .busy(busy), .echo(echo), .col_at(col_at),
    .mii_tx_en(mii_tx_en), .mii_tx_clk(mii_tx_clk), .mii_crs(mii_crs), .mii_col(mii_col));
  // FIFO stand-in: restarts on rewind and drops the frame once it is done.
  always @(posedge sys_clk) begin
    if (tx_rewind || tx_frame_done) begin
      idx <= 8'h00;
    end else if (tx_byte_take) begin
      idx <= idx + 8'h01;
    end
    if (tx_rewind) begin
      starve <= 1'b0;
    end
    if (tx_frame_done) begin
      tx_req <= 1'b0;
    end
  end
  task automatic print_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One bus transfer; the request stands until pready is seen at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      print_verdict();
    end
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK(rdv, e)
    `CHK(rerr, ee)
  endtask
  // Clearing by writing ones must leave nothing set and drop the interrupt.
  task automatic clr(input logic [5:0] fl);
    wr(IST_OFFSET, {9'h0, fl, 17'h0});
    rd(IST_OFFSET, 32'h0, 1'b0);
    `CHK(tx_irq, 1'b0)
  endtask
  // Queue one frame, let the link run it, and count the automatic restarts.
  task automatic send(input logic [2:0] cmd, input int n, input logic [7:0] cat,
      input logic ec, input int bz, input logic st, input int rew);
    int k = 0;
    nrew = 0;
    wr(CMD_OFFSET, {29'h0, cmd});
    col_at <= cat;
    echo <= ec;
    busy <= (bz != 0);
    starve <= st;
    len <= n;
    tx_req <= 1'b1;
    run <= 1'b1;
    if (bz != 0) begin
      repeat (bz) @(posedge sys_clk);
      busy <= 1'b0;
    end
    do begin
      @(posedge sys_clk);
      k++;
      nrew += int'(tx_rewind === 1'b1);
    end while (tx_frame_done !== 1'b1 && k < 20000);
    if (k >= 20000) begin
      errors++;
      print_verdict();
    end
    repeat (250) @(posedge sys_clk);
    run <= 1'b0;
    `CHK(nrew, rew)
  endtask
  task automatic frame(input logic [2:0] cmd, input int n, input logic [7:0] cat,
      input logic ec, input int bz, input logic st, input logic [5:0] fl, input int rew);
    send(cmd, n, cat, ec, bz, st, rew);
    rd(IST_OFFSET, {9'h0, fl, 17'h10000}, 1'b0);
    `CHK(tx_irq, 1'b1)
    clr(fl);
  endtask
  // Reset, register defaults, then twelve frames covering all six transmit events.
  initial begin
    {rst_n, psel, penable, pwrite, run, busy, echo, starve, tx_req} = 9'h000;
    paddr = 12'h000;
    pwdata = 32'h0;
    col_at = 8'h00;
    idx = 8'h00;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(CMD_OFFSET, 32'h0, 1'b0);
    rd(THR_OFFSET, {24'h0, THR_RESET}, 1'b0);
    rd(IEN_OFFSET, 32'h0, 1'b0);
    rd(IST_OFFSET, 32'h0, 1'b0);
    rd(12'h0FC, 32'h0, 1'b1);
    wr(IEN_OFFSET, 32'hFFFFFFFF);
    rd(IEN_OFFSET, 32'h007F0000, 1'b0);
    send(3'h0, 4, 8'h00, 1'b1, 1'b0, 1'b0, 0);
    wr(IST_OFFSET, 32'h0);
    rd(IST_OFFSET, {9'h0, CP, 17'h10000}, 1'b0);
    wr(IEN_OFFSET, 32'h007E0000);
    `CHK(tx_irq, 1'b0)
    wr(IEN_OFFSET, 32'h00010000);
    rd(IST_OFFSET, {9'h0, CP, 17'h0}, 1'b0);
    `CHK(tx_irq, 1'b0)
    wr(IEN_OFFSET, 32'hFFFFFFFF);
    `CHK(tx_irq, 1'b1)
    clr(CP);
    frame(3'h0, 4, 8'h00, 1'b0, 1'b0, 1'b0, NC | CP, 0);
    frame(3'h0, 4, 8'h00, 1'b1, 1'b0, 1'b1, UF | CP, 1);
    wr(THR_OFFSET, 32'h80);
    rd(THR_OFFSET, 32'h80, 1'b0);
    frame(3'h0, 4, 8'h01, 1'b1, 1'b0, 1'b0, AB, 15);
    frame(3'h2, 4, 8'h01, 1'b0, 1'b0, 1'b0, CP, 0);
    frame(3'h2, 80, 8'h94, 1'b0, 1'b0, 1'b0, CP, 0);
    frame(3'h0, 80, 8'h94, 1'b1, 1'b0, 1'b0, LC, 0);
    frame(3'h0, 4, 8'h00, 1'b1, 100, 1'b0, XD | CP, 0);
    frame(3'h4, 4, 8'h00, 1'b1, 100, 1'b0, CP, 0);
    frame(3'h4, 4, 8'h00, 1'b1, DEFER_100M_CYC + 100, 1'b0, XD | CP, 0);
    frame(3'h1, 4, 8'h00, 1'b1, 100, 1'b0, CP, 0);
    frame(3'h2, 4, 8'h00, 1'b1, 100, 1'b0, CP, 0);
    print_verdict();
  end
endmodule
